// File: serial_flags_pkg.sv
// Shared constants, types and register map of the serial status block
package serial_flags_pkg;

	// ==========================================================
	// Register map (byte offsets on the bus)
	localparam logic [3:0] OFF_STATUS = 4'h0;
	localparam logic [3:0] OFF_DATA = 4'h4;
	localparam logic [3:0] OFF_CTRL = 4'h8;
	localparam logic [3:0] OFF_BAUD = 4'hc;
	localparam logic [2:0] HSIZE_WORD = 3'h2;

	// ==========================================================
	// Reset values
	localparam logic [7:0] STATUS_RESET = 8'hc0;
	localparam logic [15:0] BAUD_RESET = 16'h0004;

	// ==========================================================
	// Oversampling: sixteen ticks per bit
	localparam logic [3:0] OS_LAST = 4'hf;
	localparam logic [3:0] MID_FIRST = 4'h8;
	localparam logic [3:0] MID_LAST = 4'ha;
	localparam logic [3:0] EARLY_LAST = 4'h7;
	localparam logic [3:0] RX_LAST_8 = 4'h7;
	localparam logic [3:0] RX_LAST_9 = 4'h8;
	localparam logic [3:0] TX_LAST_10 = 4'h9;
	localparam logic [3:0] TX_LAST_11 = 4'ha;
	localparam logic [7:0] IDLE_TICKS_10 = 8'ha0;
	localparam logic [7:0] IDLE_TICKS_11 = 8'hb0;

	// ==========================================================
	// Types
	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;
	typedef enum logic {TX_IDLE, TX_SEND} tx_state_t;

	typedef struct packed {
		logic tx_buffer_empty;
		logic transmit_complete_flag;
		logic rx_buffer_full;
		logic idle;
		logic overrun_flag;
		logic noise_flag;
		logic framing_error_flag;
		logic parity_error_flag;
	} status_t;

	typedef struct packed {
		logic idle_count_after_stop;
		logic nine_bit_select;
		logic tx_on;
		logic parity_enable;
		logic parity_odd;
		logic break_queue;
	} ctl_t;

	typedef struct packed {
		logic rx_s1;
		logic rx_s2;
		logic [15:0] div;
		logic [15:0] baud;
		ctl_t ctl;
		status_t st;
		status_t arm;
		logic ph_valid;
		logic [3:0] ph_addr;
		logic [31:0] hrdata;
		rx_state_t rx_state;
		logic [3:0] rx_os;
		logic [3:0] rx_bit;
		logic [2:0] tot;
		logic [2:0] ones;
		logic [1:0] mones;
		logic [8:0] rx_sh;
		logic rx_par;
		logic rx_noise;
		logic [7:0] rx_data;
		logic [7:0] idle_cnt;
		logic idle_armed;
		logic idle_allowed;
		tx_state_t tx_state;
		logic [3:0] tx_os;
		logic [3:0] tx_bit;
		logic [10:0] tx_sh;
		logic [7:0] tx_buf;
		logic pend_pre;
		logic txd;
	} state_t;

endpackage : serial_flags_pkg

// File: serial_flags.sv
// Serial transceiver with status flags and an AHB-Lite register slave
//
// Implementation choices: the AHB-Lite interface to the registers and the register addresses.

// The block holds the eight status flags of the serial port with just
// enough receiver and transmitter to drive them, behind a four-word
// AHB-Lite slave. Control and baud are plain read/write words; the
// status register ignores writes.

// Notes on behaviour
// - Status register holds eight read-only flags; writes to it do nothing.
// - Transmit-empty sets at reset and when buffer moves into shifter.
// - Status read seeing transmit-empty, then data write, clears it.
// - Complete sets at reset and when empty with nothing sending.
// - After status read, data write, tx_on rise or break clears complete.
// - Receive-full sets when a character enters the receive buffer.
// - Status read seeing receive-full, then data read, clears it.
// - Idle after 10 or 11 high bit times, counted after start bit.
// - With idle_count_after_stop set, idle counting starts after stop bit.
// - Idle clears by read sequence; sets again only after a new character.
// - Character arriving while buffer full sets overrun and is discarded.
// - Status read seeing overrun, then data read, clears overrun.
// - Seven start samples, three per bit; disagreement flags noise.
// - Any status read then data read clears noise.
// - Stop bit sampled low sets framing error with receive-full.
// - Status read seeing framing error, then data read, clears it.
// - With parity enabled, wrong parity sets parity error with receive-full.
// - Status read then data read clears parity error.
// - tx_on written low then high queues an idle after current activity.
module serial_flags
	import serial_flags_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic ce,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic rxd,
	output logic txd
);

	state_t s;
	state_t n;
	logic tick;

	// Bus decode
	logic acc;
	logic hit;
	logic st_rd;
	logic dt_rd;
	logic wr_data;
	logic wr_ctl;
	logic wr_baud;

	// Control write and its side effects
	ctl_t new_ctl;
	logic tx_rise;
	logic brk_set;

	// Receiver
	logic line;
	logic mid;
	logic samp;
	logic val;
	logic noisy;
	logic perr;
	logic [7:0] rx_byte;
	logic [7:0] idle_need;

	// Transmitter
	logic [8:0] word9;
	logic par;

	// Frozen state also stalls the bus, so no transfer is lost
	assign hreadyout = ce;
	assign hresp = 1'b0;
	assign hrdata = s.hrdata;
	assign txd = s.txd;

	// ==========================================================
	// Next-state logic
	// Every field of n starts as a copy of s, so whatever no branch
	// touches simply holds. Later assignments override earlier ones:
	// the clears of the read sequences come first and the hardware
	// sets follow, which is how a set in the same cycle as a clear
	// wins.

	always_comb begin
		n = s;
		tick = 1'b0;
		// Two-stage synchroniser on the serial input; only the
		// second stage feeds the receiver
		n.rx_s1 = rxd;
		n.rx_s2 = s.rx_s1;
		line = s.rx_s2;

		// ======================================================
		// Oversample tick
		// A baud value of 0 gives a tick on every clock
		if (s.div == 16'h0000) begin
			n.div = s.baud;
			tick = 1'b1;
		end else begin
			n.div = s.div - 16'h0001;
		end

		// ======================================================
		// Bus: reads act in the address phase, writes in data phase
		// Read side effects fall on the address-phase edge, so the
		// status arming and the data-read clears line up with the
		// value that software is handed in the data phase. Writes
		// wait for hwdata, one cycle later.
		acc = hsel && hready && htrans[1] && (hsize == HSIZE_WORD);
		hit = acc && (haddr[31:4] == 28'h0000000);
		st_rd = hit && !hwrite && (haddr[3:0] == OFF_STATUS);
		dt_rd = hit && !hwrite && (haddr[3:0] == OFF_DATA);
		n.ph_valid = hit && hwrite;
		n.ph_addr = haddr[3:0];
		n.hrdata = 32'h00000000;
		if (hit && !hwrite) begin
			unique case (haddr[3:0])
				OFF_STATUS: n.hrdata = {24'h000000, s.st};
				OFF_DATA: n.hrdata = {24'h000000, s.rx_data};
				OFF_CTRL: n.hrdata = {26'h0000000, s.ctl};
				OFF_BAUD: n.hrdata = {16'h0000, s.baud};
				default: n.hrdata = 32'h00000000;
			endcase
		end
		// No status write path exists at all
		wr_data = s.ph_valid && (s.ph_addr == OFF_DATA);
		wr_ctl = s.ph_valid && (s.ph_addr == OFF_CTRL);
		wr_baud = s.ph_valid && (s.ph_addr == OFF_BAUD);
		new_ctl = ctl_t'(hwdata[5:0]);
		tx_rise = wr_ctl && !s.ctl.tx_on && new_ctl.tx_on;
		brk_set = wr_ctl && new_ctl.break_queue;
		if (wr_ctl) begin
			n.ctl = new_ctl;
		end
		if (wr_baud) begin
			n.baud = hwdata[15:0];
		end
		if (wr_data) begin
			n.tx_buf = hwdata[7:0];
		end
		if (tx_rise) begin
			n.pend_pre = 1'b1;
		end

		// ======================================================
		// Clearing sequences; sets below win over these clears
		// Noise and parity arm on any status read; the other flags
		// arm only when the read showed them set, so a flag raised
		// between the two accesses survives.
		if (st_rd) begin
			n.arm = s.st;
			n.arm.noise_flag = 1'b1;
			n.arm.parity_error_flag = 1'b1;
		end
		if (dt_rd) begin
			if (s.arm.rx_buffer_full) n.st.rx_buffer_full = 1'b0;
			if (s.arm.idle) n.st.idle = 1'b0;
			if (s.arm.overrun_flag) n.st.overrun_flag = 1'b0;
			if (s.arm.noise_flag) n.st.noise_flag = 1'b0;
			if (s.arm.framing_error_flag) begin
				n.st.framing_error_flag = 1'b0;
			end
			if (s.arm.parity_error_flag) begin
				n.st.parity_error_flag = 1'b0;
			end
			n.arm[5:0] = 6'h00;
		end
		if (wr_data && s.arm.tx_buffer_empty) begin
			n.st.tx_buffer_empty = 1'b0;
			n.arm.tx_buffer_empty = 1'b0;
		end
		if ((wr_data || tx_rise || brk_set)
			&& s.arm.transmit_complete_flag) begin
			n.st.transmit_complete_flag = 1'b0;
			n.arm.transmit_complete_flag = 1'b0;
		end

		// ======================================================
		// Receiver
		// Sample points sit in the middle of each bit; the start bit
		// also takes four early samples so that a short glitch is
		// seen as noise or rejected as a false start.
		mid = (s.rx_os >= MID_FIRST) && (s.rx_os <= MID_LAST);
		samp = mid || ((s.rx_state == RX_START) && s.rx_os[0]
			&& (s.rx_os <= EARLY_LAST));
		val = (s.mones >= 2'h2);
		noisy = (s.ones != 3'h0) && (s.ones != s.tot);
		perr = s.ctl.parity_enable
			&& (s.rx_par != s.ctl.parity_odd);
		if (s.ctl.nine_bit_select) begin
			rx_byte = s.rx_sh[7:0];
			idle_need = IDLE_TICKS_11;
		end else begin
			// With parity the top data position holds the parity
			// bit, so bit 7 of the byte reads as 0
			rx_byte = s.ctl.parity_enable ? {1'b0, s.rx_sh[7:1]}
				: s.rx_sh[8:1];
			idle_need = IDLE_TICKS_10;
		end
		if (tick) begin
			if (s.idle_armed) begin
				if (!line) begin
					n.idle_cnt = 8'h00;
				end else if (s.idle_cnt != 8'hff) begin
					// Saturates, so a long quiet line never wraps
					// back below the threshold
					n.idle_cnt = s.idle_cnt + 8'h01;
				end
			end
			unique case (s.rx_state)
				RX_IDLE: begin
					if (!line) begin
						n.rx_state = RX_START;
						n.rx_os = 4'h0;
						n.tot = 3'h0;
						n.ones = 3'h0;
						n.mones = 2'h0;
						n.rx_noise = 1'b0;
						n.rx_par = 1'b0;
						n.rx_bit = 4'h0;
						n.rx_sh = 9'h000;
						n.idle_armed = 1'b0;
					end
				end
				RX_START, RX_DATA, RX_STOP: begin
					n.rx_os = s.rx_os + 4'h1;
					if (samp) begin
						n.tot = s.tot + 3'h1;
						n.ones = s.ones + {2'h0, line};
						if (mid) n.mones = s.mones + {1'b0, line};
					end
					if (s.rx_os == OS_LAST) begin
						n.tot = 3'h0;
						n.ones = 3'h0;
						n.mones = 2'h0;
						n.rx_noise = s.rx_noise || noisy;
						if (s.rx_state == RX_START) begin
							if (val) begin
								n.rx_state = RX_IDLE;
							end else begin
								n.rx_state = RX_DATA;
								if (!s.ctl.idle_count_after_stop) begin
									n.idle_armed = 1'b1;
									n.idle_cnt = 8'h00;
								end
							end
						end else if (s.rx_state == RX_DATA) begin
							n.rx_sh = {val, s.rx_sh[8:1]};
							n.rx_par = s.rx_par ^ val;
							n.rx_bit = s.rx_bit + 4'h1;
							if (s.rx_bit == (s.ctl.nine_bit_select
								? RX_LAST_9 : RX_LAST_8)) begin
								n.rx_state = RX_STOP;
							end
						end else begin
							n.rx_state = RX_IDLE;
							if (s.ctl.idle_count_after_stop) begin
								n.idle_armed = 1'b1;
								n.idle_cnt = 8'h00;
							end
							// Tested after this cycle's clears: a character
							// landing with the clearing read is accepted
							if (n.st.rx_buffer_full) begin
								// New character and its errors dropped
								n.st.overrun_flag = 1'b1;
							end else begin
								n.rx_data = rx_byte;
								n.st.rx_buffer_full = 1'b1;
								n.st.noise_flag = n.rx_noise;
								n.st.framing_error_flag = !val;
								n.st.parity_error_flag = perr;
								n.idle_allowed = 1'b1;
							end
						end
					end
				end
			endcase
		end
		// Only one idle report per received character
		if (s.idle_allowed && (s.idle_cnt >= idle_need)) begin
			n.st.idle = 1'b1;
			n.idle_allowed = 1'b0;
		end

		// ======================================================
		// Transmitter: break first, then queued idle, then data
		// Break keeps sending zero frames while break_queue stays
		// set; a queued preamble is one all-ones frame.
		par = s.ctl.parity_odd ^ (s.ctl.nine_bit_select
			? ^s.tx_buf : ^s.tx_buf[6:0]);
		// Without parity in 9-bit mode the ninth bit is sent as 1
		if (!s.ctl.parity_enable) begin
			word9 = s.ctl.nine_bit_select ? {1'b1, s.tx_buf}
				: {1'b1, s.tx_buf};
		end else if (s.ctl.nine_bit_select) begin
			word9 = {par, s.tx_buf};
		end else begin
			word9 = {1'b1, par, s.tx_buf[6:0]};
		end
		if (tick) begin
			unique case (s.tx_state)
				TX_IDLE: begin
					if (s.ctl.tx_on) begin
						n.tx_os = 4'h0;
						n.tx_bit = 4'h0;
						n.tx_state = TX_SEND;
						if (s.ctl.break_queue) begin
							n.tx_sh = 11'h000;
						end else if (s.pend_pre) begin
							n.tx_sh = 11'h7ff;
							n.pend_pre = tx_rise;
						end else if (!s.st.tx_buffer_empty) begin
							n.tx_sh = {1'b1, word9, 1'b0};
							n.st.tx_buffer_empty = 1'b1;
						end else begin
							n.tx_state = TX_IDLE;
						end
					end
				end
				TX_SEND: begin
					n.tx_os = s.tx_os + 4'h1;
					if (s.tx_os == OS_LAST) begin
						// Ones fill from the top, so the stop bit
						// and any trailing time come out high
						n.tx_sh = {1'b1, s.tx_sh[10:1]};
						n.tx_bit = s.tx_bit + 4'h1;
						if (s.tx_bit == (s.ctl.nine_bit_select
							? TX_LAST_11 : TX_LAST_10)) begin
							n.tx_state = TX_IDLE;
						end
					end
				end
			endcase
		end
		// Next-state values, so complete is never set in the
		// cycle in which the shifter loads
		if (n.st.tx_buffer_empty && (n.tx_state == TX_IDLE)
			&& !n.pend_pre
			&& !(n.ctl.tx_on && n.ctl.break_queue)) begin
			n.st.transmit_complete_flag = 1'b1;
		end
		n.txd = (n.tx_state == TX_SEND) ? n.tx_sh[0] : 1'b1;
	end

	// ==========================================================
	// State register
	// Only constants in the reset branch; ce low freezes every
	// field, the synchroniser included

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s <= '0;
			s.rx_s1 <= 1'b1;
			s.rx_s2 <= 1'b1;
			s.baud <= BAUD_RESET;
			s.st <= STATUS_RESET;
			s.txd <= 1'b1;
		end else if (ce) begin
			s <= n;
		end
	end

endmodule : serial_flags

// File: serial_flags_checker.sv
// Port checker for the serial status block
module serial_flags_checker
	import serial_flags_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic ce,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic txd
);
	logic take;
	logic rd_ph;
	logic lo_ph;
	logic st_ph;
	logic [2:0] age;
	default clocking @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	assign take = hsel && hready && htrans[1] && !hwrite && hsize == HSIZE_WORD;
	// Phase flags freeze with ce, like the block's own state
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rd_ph <= 1'b0;
			lo_ph <= 1'b0;
			st_ph <= 1'b0;
			age <= 3'h0;
		end else begin
			age <= age + {2'h0, age != 3'h7};
			if (ce) begin
				rd_ph <= take;
				lo_ph <= take && haddr[31:3] == 29'h0;
				st_ph <= take && haddr == 32'h0;
			end
		end
	end
	chk_ready_ce: assert property (hreadyout == ce)
		else $error("ready differs from ce");
	chk_okay_resp: assert property (!hresp)
		else $error("response not okay");
	chk_read_quiet: assert property (!rd_ph |-> hrdata == 32'h0)
		else $error("read data outside a read");
	chk_flag_width: assert property (lo_ph |-> hrdata[31:8] == 24'h0)
		else $error("upper read bits set");
	chk_reset_flags: assert property (st_ph && age != 3'h7
		|-> hrdata[7:0] == STATUS_RESET) else $error("bad reset status");
	chk_ce_freeze: assert property (
		!ce |=> $stable(hrdata) && $stable(txd)) else $error("moved without ce");
	chk_txd_rest: assert property (
		$rose(hresetn) |-> txd && hrdata == 32'h0) else $error("not idle at reset");
	chk_idle_line: assert property (st_ph && hrdata[6] |-> txd)
		else $error("line low while complete");
endmodule : serial_flags_checker
bind serial_flags serial_flags_checker i_serial_flags_checker (.hclk, .hresetn,
	.ce, .hsel, .haddr, .htrans, .hwrite, .hsize, .hready, .hrdata, .hreadyout,
	.hresp, .txd);

// File: serial_peer.sv
// Remote serial device: drives the receive line, decodes the transmit line
module serial_peer (
	input wire logic hclk,
	output logic rxd,
	input wire logic txd
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] got[$];
	logic [7:0] v;
	initial rxd = 1'b1;
	// Sixteen clocks a bit; bit g gets a one-clock glitch mid-bit
	task automatic send(input logic [9:0] f, input int g);
		for (int i = 0; i < 10; i++) begin
			for (int c = 0; c < 16; c++) begin
				@(posedge hclk);
				rxd <= f[i] ^ (i == g && c == 11);
			end
		end
		@(posedge hclk);
		rxd <= 1'b1;
	endtask : send
	always begin
		@(negedge txd);
		repeat (8) @(posedge hclk);
		for (int i = 0; i < 8; i++) begin
			repeat (16) @(posedge hclk);
			v[i] = txd;
		end
		got.push_back(v);
		wait (txd === 1'b1);
	end
endmodule : serial_peer

// File: serial_flags_bench.sv
// Self-checking bench: bus traffic, serial frames and status flags
module serial_flags_bench import serial_flags_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [7:0] ST = {4'h0, OFF_STATUS};
	localparam logic [7:0] DT = {4'h0, OFF_DATA};
	localparam logic [7:0] CT = {4'h0, OFF_CTRL};
	localparam logic [7:0] BD = {4'h0, OFF_BAUD};
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic ce = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic hreadyout;
	logic rxd;
	logic txd;
	logic [31:0] q;
	logic [7:0] b;
	int err_total = 0;
	int total_checks = 0;
	always #50 hclk = ~hclk;
	serial_flags i_serial_flags (.hclk, .hresetn, .ce, .hsel, .haddr, .htrans,
		.hwrite, .hsize(HSIZE_WORD), .hwdata, .hready(hreadyout), .hrdata,
		.hreadyout, .hresp(), .rxd, .txd);
	serial_peer i_serial_peer (.hclk, .rxd, .txd);
	task automatic stop_test;
		$display("checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : stop_test
	task automatic cmp(input string s, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			err_total++;
			$display("BAD %s exp %h got %h", s, e, g);
		end
	endtask : cmp
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		do @(posedge hclk); while (hreadyout !== 1'b1 && ++n < 99);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1 && ++n < 99);
		q = hrdata;
		if (n == 99) begin
			err_total++;
			stop_test();
		end
	endtask : bus
	task automatic rd(input logic [7:0] a, input logic [7:0] m,
		input logic [7:0] e, input string s);
		bus(1'b0, a, 32'h0);
		cmp(s, {24'h0, e & m}, q & {24'h0, m});
	endtask : rd
	task automatic rx(input logic [9:0] f, input int g, input logic [7:0] es,
		input logic [7:0] ed);
		i_serial_peer.send(f, g);
		repeat (24) @(posedge hclk);
		rd(ST, 8'h2f, es, "rx status");
		rd(DT, 8'hff, ed, "rx data");
		rd(ST, 8'h2f, 8'h00, "rx cleared");
	endtask : rx
	task automatic txget(input logic [7:0] e);
		int n;
		n = 0;
		while (i_serial_peer.got.size() == 0 && n < 999) begin
			@(posedge hclk);
			n++;
		end
		if (n == 999) begin
			err_total++;
			stop_test();
		end
		cmp("tx byte", {24'h0, e}, {24'h0, i_serial_peer.got.pop_front()});
	endtask : txget
	function automatic logic [9:0] fr(input logic [7:0] d, input logic s);
		return {s, d, 1'b0};
	endfunction : fr
	// Bus is held off by ce low for the first cycles after reset
	initial begin
		repeat (5) @(posedge hclk);
		ce <= 1'b1;
	end
	initial begin
		void'($urandom(32'h49fabf0c));
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		rd(ST, 8'hff, STATUS_RESET, "reset status");
		bus(1'b1, ST, 32'h0);
		rd(ST, 8'hff, STATUS_RESET, "status written");
		rd(8'h10, 8'hff, 8'h00, "unmapped");
		bus(1'b1, BD, 32'h0);
		bus(1'b1, CT, 32'h8);
		for (int i = 0; i < 4; i++) begin
			b = 8'($urandom);
			rx(fr(b, 1'b1), -1, 8'h20, b);
		end
		rd(ST, 8'h20, 8'h00, "empty seen");
		i_serial_peer.send(fr(b, 1'b1), -1);
		repeat (24) @(posedge hclk);
		rd(DT, 8'hff, b, "unarmed data");
		rd(ST, 8'h20, 8'h20, "full kept");
		rd(DT, 8'hff, b, "late data");
		for (int g = 0; g < 10; g += 3) begin
			b = 8'($urandom);
			rx(fr(b, 1'b1), g, 8'h24, b);
		end
		rx(fr(b, 1'b0), -1, 8'h22, b);
		i_serial_peer.send(fr(b, 1'b1), -1);
		repeat (8) @(posedge hclk);
		rx(fr(~b, 1'b0), -1, 8'h28, b);
		bus(1'b1, CT, 32'hc);
		b = 8'($urandom) & 8'h7f;
		rx({1'b1, ^b, b[6:0], 1'b0}, -1, 8'h20, b);
		rx({1'b1, ~^b, b[6:0], 1'b0}, -1, 8'h21, b);
		for (int t = 0; t < 2; t++) begin
			bus(1'b1, CT, t ? 32'h28 : 32'h8);
			i_serial_peer.send(fr(8'hff, 1'b1), -1);
			repeat (80) @(posedge hclk);
			rd(ST, 8'h10, t ? 8'h00 : 8'h10, "idle early");
			repeat (200) @(posedge hclk);
			rd(ST, 8'h10, 8'h10, "idle late");
			rd(DT, 8'hff, 8'hff, "idle data");
			repeat (250) @(posedge hclk);
			rd(ST, 8'h10, 8'h00, "idle stays");
		end
		b = 8'($urandom);
		rd(ST, 8'hc0, 8'hc0, "tx idle");
		bus(1'b1, DT, {24'h0, b});
		repeat (4) @(posedge hclk);
		rd(ST, 8'h40, 8'h00, "tx busy");
		bus(1'b1, DT, {24'h0, ~b});
		rd(ST, 8'h80, 8'h00, "buffer held");
		txget(b);
		txget(~b);
		repeat (400) @(posedge hclk);
		rd(ST, 8'hc0, 8'hc0, "tx done");
		bus(1'b1, CT, 32'h0);
		bus(1'b1, CT, 32'h8);
		rd(ST, 8'h40, 8'h00, "preamble");
		repeat (400) @(posedge hclk);
		rd(ST, 8'h40, 8'h40, "preamble done");
		bus(1'b1, CT, 32'h9);
		rd(ST, 8'h40, 8'h00, "break");
		bus(1'b1, CT, 32'h8);
		stop_test();
	end
endmodule : serial_flags_bench
